// *** ctf_defines.svh ***
// register offsets, field positions, reset values and code points of the display fetch block
`ifndef CTF_DEFINES_SVH
`define CTF_DEFINES_SVH
`define CTF_OFS_OUT_CTRL 8'h5b
`define CTF_OFS_MODE 8'h60
`define CTF_OFS_START_LO 8'h62
`define CTF_OFS_START_MID 8'h63
`define CTF_OFS_START_HI 8'h64
`define CTF_OFS_OFFSET_LO 8'h66
`define CTF_OFS_OFFSET_HI 8'h67
`define CTF_OFS_PAN 8'h68
`define CTF_OFS_FIFO_HIGH 8'h6a
`define CTF_OFS_FIFO_LOW 8'h6b
`define CTF_PAL_BIT 0
`define CTF_BLANK_BIT 7
`define CTF_DEPTH_MSB 2
`define CTF_DEPTH_LSB 0
`define CTF_START_HI_MSB 3
`define CTF_OFFSET_HI_MSB 2
`define CTF_PAN_MSB 1
`define CTF_THR_MSB 5
`define CTF_DEPTH_4BPP 3'h2
`define CTF_DEPTH_8BPP 3'h3
`define CTF_DEPTH_15BPP 3'h4
`define CTF_DEPTH_16BPP 3'h5
`define CTF_RST_BYTE 8'h00
`define CTF_THR_AUTO 6'h00
`endif

// *** ctf_pkg.sv ***
// types shared by the display fetch block
`default_nettype none
package ctf_pkg;
	typedef enum logic [1:0] {CTF_ST_IDLE, CTF_ST_FETCH, CTF_ST_BLANK} ctf_state_e;
	typedef struct packed {
		logic [15:0] data;
		logic bypass;
	} ctf_pix_s;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ctf_reg_req_s;
endpackage
`default_nettype wire

// *** ctf_fifo.sv ***
// small word fifo with valid/ready on both sides and a clear
`default_nettype none
module ctf_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [$clog2(DEPTH+1)-1:0] level_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [$clog2(DEPTH+1)-1:0] count;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rptr];
	assign level_o = count;
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wptr] <= in_data_i;
	end
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end
		else if (clear_i)
		begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
			if (pop)
				rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
			count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
		end
	end
endmodule
`default_nettype wire

// *** ctf_fetch.sv ***
// crt/tv display configuration registers, line fetch and pixel unpacking
//
// How it works
// - tv format bit one selects pal output, zero selects ntsc.
// - blank bit set stops the pipeline and forces pixel outputs to zero.
// - depth codes 010/011/100/101 give 4/8/15/16 bpp; others reserved.
// - 15 and 16 bpp pixels bypass the colour look-up table.
// - start address is 20 bits from three bytes, top nibble in third.
// - start address counts words: zero is the first memory word.
// - 11-bit line offset is word distance between consecutive line starts.
// - offsets wider than the display are honoured for virtual images.
// - non-zero pan value shifts the display left by that many pixels.
// - pan uses two bits at 4 bpp, one at 8 bpp, none above.
// - six-bit fifo high threshold tunes arbitration; zero means automatic.
// - six-bit fifo low threshold zero is chosen automatically too.
`include "ctf_defines.svh"
`default_nettype none
module ctf_fetch #(
	parameter int FIFO_DEPTH = 4,
	parameter logic [5:0] AUTO_HIGH = 6'h01,
	parameter logic [5:0] AUTO_LOW = 6'h03
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// timing from the sync generator
	input wire logic frame_start_i,
	input wire logic line_start_i,
	input wire logic [10:0] line_words_i,
	// display memory read
	output logic mem_req_o,
	output logic [19:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_data_i,
	output logic mem_urgent_o,
	// pixel stream
	output logic pix_valid_o,
	input wire logic pix_ready_i,
	output ctf_pkg::ctf_pix_s pix_o,
	// configuration seen by the output stage
	output logic tv_pal_o,
	output logic blank_o
);
	import ctf_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	ctf_reg_req_s req;
	logic out_pal;
	logic disp_blank;
	logic [2:0] depth;
	logic [19:0] start_addr;
	logic [10:0] line_offset;
	logic [1:0] pan;
	logic [5:0] thr_high;
	logic [5:0] thr_low;
	logic [7:0] next_rdata;

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	wire wr_out = req.wr && req.addr == `CTF_OFS_OUT_CTRL;
	wire wr_mode = req.wr && req.addr == `CTF_OFS_MODE;
	wire wr_slo = req.wr && req.addr == `CTF_OFS_START_LO;
	wire wr_smid = req.wr && req.addr == `CTF_OFS_START_MID;
	wire wr_shi = req.wr && req.addr == `CTF_OFS_START_HI;
	wire wr_olo = req.wr && req.addr == `CTF_OFS_OFFSET_LO;
	wire wr_ohi = req.wr && req.addr == `CTF_OFS_OFFSET_HI;
	wire wr_pan = req.wr && req.addr == `CTF_OFS_PAN;
	wire wr_fh = req.wr && req.addr == `CTF_OFS_FIFO_HIGH;
	wire wr_fl = req.wr && req.addr == `CTF_OFS_FIFO_LOW;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			out_pal <= 1'b0;
			disp_blank <= 1'b0;
			depth <= 3'h0;
			start_addr <= 20'h00000;
			line_offset <= 11'h000;
			pan <= 2'h0;
			thr_high <= `CTF_THR_AUTO;
			thr_low <= `CTF_THR_AUTO;
		end
		else
		begin
			if (wr_out)
				out_pal <= req.wdata[`CTF_PAL_BIT];
			if (wr_mode)
				disp_blank <= req.wdata[`CTF_BLANK_BIT];
			if (wr_mode)
				depth <= req.wdata[`CTF_DEPTH_MSB:`CTF_DEPTH_LSB];
			if (wr_slo)
				start_addr[7:0] <= req.wdata;
			if (wr_smid)
				start_addr[15:8] <= req.wdata;
			if (wr_shi)
				start_addr[19:16] <= req.wdata[`CTF_START_HI_MSB:0];
			if (wr_olo)
				line_offset[7:0] <= req.wdata;
			if (wr_ohi)
				line_offset[10:8] <= req.wdata[`CTF_OFFSET_HI_MSB:0];
			if (wr_pan)
				pan <= req.wdata[`CTF_PAN_MSB:0];
			if (wr_fh)
				thr_high <= req.wdata[`CTF_THR_MSB:0];
			if (wr_fl)
				thr_low <= req.wdata[`CTF_THR_MSB:0];
		end
	end

	// read mux, answered one cycle after the strobe
	always_comb
	begin
		next_rdata = 8'h00;
		case (req.addr)
			`CTF_OFS_OUT_CTRL: next_rdata = {7'h00, out_pal};
			`CTF_OFS_MODE: next_rdata = {disp_blank, 4'h0, depth};
			`CTF_OFS_START_LO: next_rdata = start_addr[7:0];
			`CTF_OFS_START_MID: next_rdata = start_addr[15:8];
			`CTF_OFS_START_HI: next_rdata = {4'h0, start_addr[19:16]};
			`CTF_OFS_OFFSET_LO: next_rdata = line_offset[7:0];
			`CTF_OFS_OFFSET_HI: next_rdata = {5'h00, line_offset[10:8]};
			`CTF_OFS_PAN: next_rdata = {6'h00, pan};
			`CTF_OFS_FIFO_HIGH: next_rdata = {2'h0, thr_high};
			`CTF_OFS_FIFO_LOW: next_rdata = {2'h0, thr_low};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= 8'h00;
		else if (req.rd)
			rdata_o <= next_rdata;
		else
			rdata_o <= 8'h00;
	end

	// ****************************************
	// depth decode
	// ****************************************
	function automatic logic [1:0] last_sub(input logic [2:0] d);
		case (d)
			`CTF_DEPTH_4BPP: last_sub = 2'd3;
			`CTF_DEPTH_8BPP: last_sub = 2'd1;
			default: last_sub = 2'd0;
		endcase
	endfunction

	function automatic logic [15:0] pick_pixel(input logic [15:0] w, input logic [2:0] d,
		input logic [1:0] idx);
		case (d)
			`CTF_DEPTH_4BPP: pick_pixel = {12'h000, w[idx*4 +: 4]};
			`CTF_DEPTH_8BPP: pick_pixel = {8'h00, w[idx[0]*8 +: 8]};
			`CTF_DEPTH_15BPP: pick_pixel = {1'b0, w[14:0]};
			default: pick_pixel = w;
		endcase
	endfunction

	wire depth_ok = depth inside {`CTF_DEPTH_4BPP, `CTF_DEPTH_8BPP, `CTF_DEPTH_15BPP,
		`CTF_DEPTH_16BPP};
	wire lut_bypass = depth == `CTF_DEPTH_15BPP || depth == `CTF_DEPTH_16BPP;
	wire [1:0] pan_eff = (depth == `CTF_DEPTH_4BPP) ? pan :
		(depth == `CTF_DEPTH_8BPP) ? {1'b0, pan[0]} : 2'd0;
	wire run = !disp_blank && depth_ok;

	assign tv_pal_o = out_pal;
	assign blank_o = disp_blank;

	// ****************************************
	// line fetch
	// ****************************************
	ctf_state_e state;
	ctf_state_e next_state;
	logic [19:0] line_base;
	logic [19:0] fetch_addr;
	logic [10:0] words_left;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [15:0] fifo_out_data;
	logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
	logic urgent;

	wire fetch_go = state == CTF_ST_FETCH && words_left != 11'h000;
	wire mem_take = fetch_go && fifo_in_ready && mem_ack_i;

	always_comb
	begin
		next_state = state;
		case (state)
			CTF_ST_IDLE:
				if (!run)
					next_state = CTF_ST_BLANK;
				else if (line_start_i)
					next_state = CTF_ST_FETCH;
			CTF_ST_FETCH:
				if (!run)
					next_state = CTF_ST_BLANK;
				else if (words_left == 11'h000 && !line_start_i)
					next_state = CTF_ST_IDLE;
			CTF_ST_BLANK:
				if (run)
					next_state = CTF_ST_IDLE;
			default: next_state = CTF_ST_BLANK;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= CTF_ST_BLANK;
			line_base <= 20'h00000;
			fetch_addr <= 20'h00000;
			words_left <= 11'h000;
		end
		else
		begin
			state <= next_state;
			if (frame_start_i)
				line_base <= start_addr;
			else if (line_start_i && run)
			begin
				fetch_addr <= line_base;
				words_left <= line_words_i;
				line_base <= line_base + 20'(line_offset);
			end
			else if (!run)
				words_left <= 11'h000;
			else if (mem_take)
			begin
				fetch_addr <= fetch_addr + 20'h00001;
				words_left <= words_left - 11'h001;
			end
		end
	end

	assign mem_req_o = fetch_go && fifo_in_ready;
	assign mem_addr_o = fetch_addr;

	// arbitration urgency with hysteresis between the two thresholds
	wire [5:0] high_eff = (thr_high == `CTF_THR_AUTO) ? AUTO_HIGH : thr_high;
	wire [5:0] low_eff = (thr_low == `CTF_THR_AUTO) ? AUTO_LOW : thr_low;
	wire [5:0] level6 = 6'(fifo_level);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			urgent <= 1'b0;
		else if (!fetch_go)
			urgent <= 1'b0;
		else if (level6 < high_eff)
			urgent <= 1'b1;
		else if (level6 >= low_eff)
			urgent <= 1'b0;
	end
	assign mem_urgent_o = urgent;

	ctf_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(line_start_i || !run),
		.in_valid_i(fetch_go && mem_ack_i),
		.in_ready_o(fifo_in_ready),
		.in_data_i(mem_data_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data),
		.level_o(fifo_level)
	);

	// ****************************************
	// pixel unpacking
	// ****************************************
	logic [1:0] sub;
	wire out_free = !pix_valid_o || pix_ready_i;
	wire pix_take = run && fifo_out_valid && out_free && !line_start_i;
	wire word_done = sub == last_sub(depth);
	assign fifo_out_ready = pix_take && word_done;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			sub <= 2'd0;
		else if (line_start_i)
			sub <= pan_eff;
		else if (pix_take)
			sub <= word_done ? 2'd0 : sub + 2'd1;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pix_valid_o <= 1'b0;
			pix_o <= '0;
		end
		else if (!run || line_start_i)
		begin
			pix_valid_o <= 1'b0;
			pix_o <= '0;
		end
		else if (out_free)
		begin
			pix_valid_o <= pix_take;
			pix_o.data <= pix_take ? pick_pixel(fifo_out_data, depth, sub) : 16'h0000;
			pix_o.bypass <= pix_take && lut_bypass;
		end
	end
endmodule
`default_nettype wire

// *** ctf_monitor.sv ***
// assertion checker bound to the display fetch block
`default_nettype none
module ctf_monitor (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register writes
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	// fetch and stream
	input wire logic line_start_i,
	input wire logic mem_req_o,
	input wire logic [19:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic pix_valid_o,
	input wire ctf_pkg::ctf_pix_s pix_o,
	input wire logic tv_pal_o,
	input wire logic blank_o
);
	import ctf_pkg::*;
	logic [2:0] dep;
	wire logic rsv = dep < 3'h2 || dep > 3'h5;
	wire logic wr_mode = wr_i && addr_i == 8'h60;
	wire logic wr_out = wr_i && addr_i == 8'h5b;
	wire logic [4:0] wid = dep == 3'h2 ? 5'h04 : dep == 3'h3 ? 5'h08 :
		dep == 3'h4 ? 5'h0f : 5'h10;
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
			dep <= 3'h0;
		else if (wr_mode)
			dep <= wdata_i[2:0];
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_take;
		mem_req_o && mem_ack_i && !line_start_i;
	endsequence
	chk_pal_select: assert property (wr_out |=> tv_pal_o == $past(wdata_i[0]))
		else $error("pal select wrong");
	chk_blank_follow: assert property (wr_mode |=> blank_o == $past(wdata_i[7]))
		else $error("blank bit wrong");
	chk_blank_quiet: assert property (blank_o && $past(blank_o) |-> !mem_req_o && pix_o == '0)
		else $error("blank not quiet");
	chk_depth_stop: assert property (rsv [*2] |-> !mem_req_o && !pix_valid_o)
		else $error("fetch in reserved depth");
	chk_depth_width: assert property (pix_valid_o |-> (pix_o.data >> wid) == 16'h0000)
		else $error("pixel wider than depth");
	chk_lut_bypass: assert property (pix_valid_o |-> pix_o.bypass == (wid > 5'h08))
		else $error("bypass wrong");
	chk_addr_step: assert property (s_take |=> mem_addr_o == $past(mem_addr_o) + 20'h00001)
		else $error("address not stepped");
	chk_addr_hold: assert property (mem_req_o && !mem_ack_i && !line_start_i |=> $stable(mem_addr_o))
		else $error("address moved");
	cov_deep_pixel: cover property (pix_valid_o && wid > 5'h08);
	cov_fetch: cover property (s_take);
	cov_blank_line: cover property (blank_o && line_start_i);
endmodule
bind ctf_fetch ctf_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .line_start_i(line_start_i), .mem_req_o(mem_req_o),
	.mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .pix_valid_o(pix_valid_o),
	.pix_o(pix_o), .tv_pal_o(tv_pal_o), .blank_o(blank_o));
`default_nettype wire

// *** ctf_mem_model.sv ***
// display memory model answering fetch requests after random waits
`default_nettype none
module ctf_mem_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// fetch port
	input wire logic req_i,
	input wire logic [19:0] addr_i,
	output logic ack_o,
	output logic [15:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 32'h60bd;
	logic go;
	wire logic [15:0] word = addr_i[15:0] ^ {addr_i[19:16], 12'ha5c};
	always @(posedge clk_i or posedge rst_i)
		if (rst_i)
			go <= 1'b0;
		else
			go <= $random(seed) % 3 != 0;
	assign ack_o = req_i && go;
	// no answer: inverse pattern so stale data never matches
	assign data_o = ack_o ? word : ~word;
endmodule
`default_nettype wire

// *** crt_tv_display_fetch_config_bench.sv ***
// self-checking bench for the display fetch block
`default_nettype none
module crt_tv_display_fetch_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ctf_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_q = 1'b0;
	logic frame_start_i = 1'b0, line_start_i = 1'b0, pix_ready_i = 1'b0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
	logic [10:0] line_words_i = 11'h003;
	logic mem_req_o, mem_ack_i, pix_valid_o, tv_pal_o, blank_o, mem_urgent_o;
	logic [19:0] mem_addr_o;
	logic [15:0] mem_data_i;
	ctf_pix_s pix_o;
	ctf_pix_s pq[$];
	logic [19:0] aq[$], rq[$];
	int err_total = 0, total_checks = 0, seed = 32'h60bd;
	logic [7:0] ra[11] = '{8'h5b, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h66, 8'h67, 8'h68,
		8'h6a, 8'h6b};
	logic [7:0] rm[11] = '{8'h01, 8'h87, 8'h00, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h07, 8'h03,
		8'h3f, 8'h3f};
	ctf_fetch i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frame_start_i(frame_start_i),
		.line_start_i(line_start_i), .line_words_i(line_words_i), .mem_req_o(mem_req_o),
		.mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i),
		.mem_urgent_o(mem_urgent_o), .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i),
		.pix_o(pix_o), .tv_pal_o(tv_pal_o), .blank_o(blank_o));
	ctf_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o),
		.addr_i(mem_addr_o), .ack_o(mem_ack_i), .data_o(mem_data_i));
	always #10 clk_i = ~clk_i;
	task automatic cmp(input logic [19:0] g, input logic [19:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_pix(input ctf_pix_s g, input ctf_pix_s e);
		cmp({3'h0, g}, {3'h0, e});
	endtask
	task automatic finish_test();
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		if (!w)
			rq.push_back({12'h000, d});
		@(posedge clk_i);
	endtask
	task automatic pulse(input logic f);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		frame_start_i <= f;
		line_start_i <= !f;
		@(posedge clk_i);
		frame_start_i <= 1'b0;
		line_start_i <= 1'b0;
		@(posedge clk_i);
	endtask
	function automatic ctf_pix_s pix_of(input logic [2:0] dep, input logic [15:0] w,
		input int p);
		ctf_pix_s x;
		x.bypass = dep > 3'h3;
		x.data = dep == 3'h2 ? {12'h000, w[4*p +: 4]} : dep == 3'h3 ? {8'h00, w[8*p +: 8]}
			: dep == 3'h4 ? {1'b0, w[14:0]} : w;
		return x;
	endfunction
	task automatic frame(input logic [2:0] dep);
		logic [19:0] base;
		logic [19:0] a;
		logic [10:0] off;
		logic [15:0] w;
		int sh;
		int per;
		base = $random(seed);
		off = $random(seed);
		per = dep == 3'h2 ? 4 : dep == 3'h3 ? 2 : 1;
		sh = dep == 3'h2 ? 3 : dep == 3'h3 ? 1 : 0;
		bus(1, 8'h60, {5'h00, dep});
		bus(1, 8'h62, base[7:0]);
		bus(1, 8'h63, base[15:8]);
		bus(1, 8'h64, {4'h0, base[19:16]});
		bus(1, 8'h66, off[7:0]);
		bus(1, 8'h67, {5'h00, off[10:8]});
		bus(1, 8'h68, 8'h03);
		pulse(1);
		repeat (2)
		begin
			for (int k = 0; k < 3; k++)
			begin
				a = base + 20'(k);
				aq.push_back(a);
				w = a[15:0] ^ {a[19:16], 12'ha5c};
				for (int p = k ? 0 : sh; p < per; p++)
					pq.push_back(pix_of(dep, w, p));
			end
			pulse(0);
			for (int i = 0; i < 500 && aq.size() + pq.size() > 0; i++)
				@(posedge clk_i);
			base = base + {9'h000, off};
		end
	endtask
	always @(posedge clk_i)
	begin
		if (rd_q)
			cmp({12'h000, rdata_o}, rq.pop_front());
		if (mem_req_o && mem_ack_i)
			cmp(mem_addr_o, aq.pop_front());
		if (pix_valid_o && pix_ready_i)
			cmp_pix(pix_o, pq.pop_front());
		rd_q <= rd_i;
		pix_ready_i <= 1'($random(seed));
	end
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ra[i])
			bus(0, ra[i], 8'h00);
		foreach (ra[i])
		begin
			bus(1, ra[i], 8'hff);
			bus(0, ra[i], rm[i]);
		end
		cmp({19'h00000, tv_pal_o}, 20'h00001);
		bus(1, 8'h5b, 8'h00);
		bus(1, 8'h6a, 8'h10);
		bus(1, 8'h6b, 8'h20);
		bus(0, 8'h6b, 8'h20);
		bus(1, 8'h6a, 8'h00);
		bus(1, 8'h6b, 8'h00);
		for (int d = 2; d < 6; d++)
			frame(3'(d));
		bus(1, 8'h60, 8'h82);
		pulse(0);
		repeat (20) @(posedge clk_i);
		cmp({17'h00000, blank_o, mem_req_o, mem_urgent_o}, 20'h00004);
		bus(1, 8'h60, 8'h07);
		pulse(0);
		repeat (20) @(posedge clk_i);
		cmp({18'h00000, pix_valid_o, mem_req_o}, 20'h00000);
		cmp(20'(aq.size() + pq.size()), 20'h00000);
		finish_test();
	end
	// watchdog at well over fifty times the expected run
	initial
	begin
		#400000;
		err_total++;
		finish_test();
	end
endmodule
`default_nettype wire
